/* File: bench/pcg_counter_group_control_properties.sv */
// Checker for the counter group control block.
// Bound to pcg_counter_group_control; sees only its ports.
`include "pcg_consts.svh"
`default_nettype none

module pcg_checker #(
    parameter int GROUPS = 4,
    parameter int COUNTERS = 16
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [11:0] wbAdr,
    input wire logic wbAck,
    input wire logic [GROUPS-1:0] eventValid,
    input wire logic [COUNTERS-1:0] counterIncrement,
    input wire logic [GROUPS-1:0] groupExport,
    input wire logic [GROUPS-1:0] groupReveal,
    input wire logic [GROUPS*8-1:0] groupRevealBank,
    input wire logic globalEnable
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    property p_ack_next;
        wbCyc && wbStb && !wbAck |=> wbAck;
    endproperty
    a_ack_next: assert property (p_ack_next)
        else $error("request not answered next cycle");
    property p_ack_pulse;
        wbAck |=> !wbAck;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack longer than one cycle");
    property p_gate_off;
        !globalEnable |-> counterIncrement == '0;
    endproperty
    a_gate_off: assert property (p_gate_off)
        else $error("count while globally disabled");
    property p_need_event;
        |counterIncrement[COUNTERS/GROUPS-1:0] |-> eventValid[0];
    endproperty
    a_need_event: assert property (p_need_event)
        else $error("count without event");
    property p_export_src;
        $changed(groupExport) |-> $past(wbAck) && $past(wbWe);
    endproperty
    a_export_src: assert property (p_export_src)
        else $error("export changed without write");
    property p_reveal_src;
        $changed(groupReveal) |-> $past(wbAck) && $past(wbWe);
    endproperty
    a_reveal_src: assert property (p_reveal_src)
        else $error("reveal changed without write");
    property p_bank_src;
        $changed(groupRevealBank) |-> $past(wbAck) && $past(wbWe);
    endproperty
    a_bank_src: assert property (p_bank_src)
        else $error("reveal bank changed without write");
    property p_global_src;
        $changed(globalEnable) |-> $past(wbAck) && $past(wbWe)
            && $past(wbAdr) == `PCG_OFS_MONITOR_CONTROL;
    endproperty
    a_global_src: assert property (p_global_src)
        else $error("global enable changed without write");
endmodule

bind pcg_counter_group_control pcg_checker #(
    .GROUPS(GROUPS), .COUNTERS(COUNTERS)
) pcg_checker_i (
    .mclk(mclk), .nrst(nrst), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbWe(wbWe), .wbAdr(wbAdr), .wbAck(wbAck), .eventValid(eventValid),
    .counterIncrement(counterIncrement), .groupExport(groupExport),
    .groupReveal(groupReveal), .groupRevealBank(groupRevealBank),
    .globalEnable(globalEnable)
);

`default_nettype wire

/* File: bench/pcg_counter_group_control_test.sv */
// Self-checking bench for the counter group control block.
// Assumes default design parameters: 4 groups, 16 counters.
`include "pcg_consts.svh"
`default_nettype none

module pcg_counter_group_control_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk = 1'b0, nrst = 1'b0, wbCyc = 1'b0, wbStb = 1'b0;
    logic wbWe = 1'b0, wbAck;
    logic [11:0] wbAdr = 12'h000;
    logic [3:0] wbSel = 4'hF, eventValid = 4'hF;
    logic [31:0] wbDatW = 32'h0, wbDatR, eventBank = 32'h0, bankOut;
    logic [63:0] eventStreamId = 64'h0;
    logic [15:0] counterIncrement;
    logic [3:0] groupExport, groupReveal;
    logic globalEnable;
    int failCount = 0, comparisons = 0;
    logic [31:0] cfgTab[6] = '{32'h0800, 32'h0, 32'h0900, 32'h0900,
                               32'h0A07, 32'h0A07};
    logic [15:0] idTab[6] = '{16'h0, 16'h0, 16'h12F0, 16'h1231, 16'h0,
                              16'h0};
    logic [7:0] bankTab[6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h07, 8'h08};
    logic hitTab[6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};

    pcg_counter_group_control pcg_counter_group_control_i (
        .mclk(mclk), .nrst(nrst), .wbCyc(wbCyc), .wbStb(wbStb),
        .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW),
        .wbDatR(wbDatR), .wbAck(wbAck), .eventValid(eventValid),
        .eventStreamId(eventStreamId), .eventBank(eventBank),
        .counterIncrement(counterIncrement), .groupExport(groupExport),
        .groupReveal(groupReveal), .groupRevealBank(bankOut),
        .globalEnable(globalEnable)
    );

    always #10 mclk = ~mclk;

    // ==========================================================
    // Bus and compare tasks
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, failCount);
        if (failCount == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failCount++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wbCycle(input logic we, input logic [11:0] adr,
                           input logic [31:0] dat, input logic [3:0] sel,
                           output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge mclk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbDatW <= dat;
        wbSel <= sel;
        do begin
            @(posedge mclk);
            n++;
        end while (wbAck !== 1'b1 && n < 20);
        rd = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        if (n >= 20) begin
            failCount++;
            conclude();
        end
    endtask

    task automatic wr(input logic [11:0] adr, input logic [31:0] dat,
                      input logic [3:0] sel = 4'hF);
        logic [31:0] unused;
        wbCycle(1'b1, adr, dat, sel, unused);
    endtask

    task automatic rdChk(input logic [11:0] adr, input logic [31:0] exp);
        logic [31:0] rd;
        wbCycle(1'b0, adr, 32'h0, 4'hF, rd);
        check(rd, exp);
    endtask

    // ==========================================================
    // Test sequence
    initial begin
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        rdChk(`PCG_OFS_GROUP_CONFIG, 32'h0400_0000);
        rdChk(`PCG_OFS_GROUP_CONFIG + 12'h8, 32'h0402_0000);
        rdChk(12'h7FC, 32'h0);
        wr(`PCG_OFS_GROUP_CONFIG + 12'h4, 32'hFFFF_FEFF);
        rdChk(`PCG_OFS_GROUP_CONFIG + 12'h4, 32'h0401_1EFF);
        wr(`PCG_OFS_MONITOR_CONTROL, 32'h0000_0011);
        @(negedge mclk);
        check(groupExport, 32'h2);
        check(groupReveal, 32'h2);
        check(bankOut, 32'h0000_FF00);
        check(globalEnable, 32'h1);
        wr(`PCG_OFS_GROUP_CONFIG + 12'h4, 32'h0000_0055, 4'h1);
        rdChk(`PCG_OFS_GROUP_CONFIG + 12'h4, 32'h0401_1E55);
        $display("test registers done");
        wr(`PCG_OFS_ENABLE_SET, 32'hFFFF_0015);
        rdChk(`PCG_OFS_ENABLE_SET, 32'h0000_0015);
        wr(`PCG_OFS_ENABLE_CLEAR, 32'h0000_0004);
        wr(`PCG_OFS_ENABLE_SET, 32'h0);
        rdChk(`PCG_OFS_ENABLE_CLEAR, 32'h0000_0011);
        rdChk(`PCG_OFS_ENABLE_SET, 32'h0000_0011);
        $display("test enables done");
        wr(`PCG_OFS_STREAM_MATCH, 32'h00F0_9200);
        rdChk(`PCG_OFS_STREAM_MATCH, 32'h00F0_9200);
        for (int i = 0; i < 6; i++) begin
            wr(`PCG_OFS_GROUP_CONFIG, cfgTab[i]);
            eventStreamId <= {48'h0, idTab[i]};
            eventBank <= {24'h0, bankTab[i]};
            @(negedge mclk);
            check(counterIncrement, {15'h0, hitTab[i]});
        end
        wr(`PCG_OFS_GROUP_CONFIG, 32'h0000_0900);
        eventStreamId <= 64'h12F0;
        wr(`PCG_OFS_WIDE_ID_CTRL, 32'h1);
        @(negedge mclk);
        check(counterIncrement, 32'h0);
        wr(`PCG_OFS_WIDE_ID_CTRL, 32'h0);
        @(negedge mclk);
        check(counterIncrement, 32'h1);
        @(posedge mclk);
        eventValid <= 4'hE;
        @(negedge mclk);
        check(counterIncrement, 32'h0);
        @(posedge mclk);
        eventValid <= 4'hF;
        $display("test filters done");
        wr(`PCG_OFS_MONITOR_CONTROL, 32'h0);
        @(negedge mclk);
        check(counterIncrement, 32'h0);
        check(groupExport, 32'h0);
        rdChk(`PCG_OFS_ENABLE_SET, 32'h0000_0011);
        $display("test global gate done");
        conclude();
    end
endmodule

`default_nettype wire

/* File: hdl/pcg_consts.svh */
// Register offsets, field positions and reset values of the counter
// group control block. Assumes a 32-bit byte-addressed register bus.
`ifndef PCG_CONSTS_SVH
`define PCG_CONSTS_SVH

// ==================================================================
// Register map (byte offsets)
`define PCG_OFS_MONITOR_CONTROL 12'h000
`define PCG_OFS_WIDE_ID_CTRL 12'h004
`define PCG_OFS_GROUP_CONFIG 12'h100
`define PCG_OFS_STREAM_MATCH 12'h200
`define PCG_OFS_ENABLE_SET 12'h300
`define PCG_OFS_ENABLE_CLEAR 12'h380

// ==================================================================
// Field positions
`define PCG_CFG_TOTAL_HI 27
`define PCG_CFG_TOTAL_LO 24
`define PCG_CFG_TAG_HI 22
`define PCG_CFG_TAG_LO 16
`define PCG_CFG_EXPORT 12
`define PCG_CFG_ENABLE 11
`define PCG_CFG_REVEAL 10
`define PCG_CFG_FILT_HI 9
`define PCG_CFG_FILT_LO 8
`define PCG_CFG_INDEX_HI 7
`define PCG_CFG_INDEX_LO 0
`define PCG_SM_MASK_LO 16
`define PCG_MC_ENABLE 0
`define PCG_MC_EXPORT 4

// ==================================================================
// Reset values (unknown on the device; zero chosen)
`define PCG_RST_WORD 32'h0000_0000

`endif

/* File: hdl/pcg_counter_group_control.sv */
// Configuration and enable control for a performance counter bank.
// Assumes a classic Wishbone master on mclk and event sources on mclk.
// Functional notes
// - Config bits 27:24 show group counter total
// - Config bits 22:16 show stream group tag
// - Config bit 12 is group event export
// - Config bit 11 is group count enable
// - Bank reveal bit exposes group to bank
// - Filter: global, stream, bank, reserved
// - Mask bit one excludes ID bit
// - Stream match low half holds ID
// - Unimplemented mask/ID bits read zero
// - Top mask/ID bits reserved without wide IDs
// - Clear register x maps counters x*32+j
// - Clear write one disables counter
// - Set write one enables counter
// - Set and clear share one state
// - Global enable off gates, keeps bits
// - All registers 32 bits, init first
// - Monitor control bit 0 global enable
`include "pcg_consts.svh"
`default_nettype none

module pcg_counter_group_control #(
    parameter int GROUPS = 4,
    parameter int COUNTERS = 16,
    parameter int ID_BITS = 16,
    parameter logic [3:0] GROUP_TOTAL = 4'h4,
    parameter logic [6:0] TAG_BASE = 7'h00
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [11:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [31:0] wbDatW,
    output logic [31:0] wbDatR,
    output logic wbAck,
    input wire logic [GROUPS-1:0] eventValid,
    input wire logic [GROUPS*16-1:0] eventStreamId,
    input wire logic [GROUPS*8-1:0] eventBank,
    output logic [COUNTERS-1:0] counterIncrement,
    output logic [GROUPS-1:0] groupExport,
    output logic [GROUPS-1:0] groupReveal,
    output logic [GROUPS*8-1:0] groupRevealBank,
    output logic globalEnable
);
    localparam int SETREGS = (COUNTERS + 31) / 32;
    localparam int GSW = (GROUPS > 1) ? $clog2(GROUPS) : 1;
    localparam logic [11:0] OFS_CFG = `PCG_OFS_GROUP_CONFIG;
    localparam logic [11:0] OFS_SM = `PCG_OFS_STREAM_MATCH;
    localparam logic [11:0] OFS_SET = `PCG_OFS_ENABLE_SET;
    localparam logic [11:0] OFS_CLR = `PCG_OFS_ENABLE_CLEAR;

    // ==============================================================
    // Implemented-bit masks
    function automatic logic [15:0] idMask(input logic wide);
        logic [15:0] m;
        m = '0;
        for (int i = 0; i < 16; i++) begin
            if (i < ID_BITS) begin
                m[i] = 1'b1;
            end
        end
        if (!wide) begin
            m[15] = 1'b0;
        end
        return m;
    endfunction

    function automatic logic [31:0] setMask(input int x);
        logic [31:0] m;
        m = '0;
        for (int j = 0; j < 32; j++) begin
            if (x * 32 + j < COUNTERS) begin
                m[j] = 1'b1;
            end
        end
        return m;
    endfunction

    function automatic logic [31:0] laneMask(input logic [3:0] sel);
        return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction

    // ==============================================================
    // Address windows and configuration word
    // Group windows: 256 bytes, one word per group
    function automatic logic inPage(input logic [11:0] adr,
                                    input logic [11:0] base);
        return adr[11:8] == base[11:8];
    endfunction

    // Enable windows: 128 bytes, one word per 32 counters
    function automatic logic inHalfPage(input logic [11:0] adr,
                                        input logic [11:0] base);
        return adr[11:7] == base[11:7];
    endfunction

    function automatic logic [31:0] packCfg(input logic xp, input logic en,
                                            input logic rv,
                                            input logic [1:0] fs,
                                            input logic [7:0] ix);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`PCG_CFG_EXPORT] = xp;
        w[`PCG_CFG_ENABLE] = en;
        w[`PCG_CFG_REVEAL] = rv;
        w[`PCG_CFG_FILT_HI:`PCG_CFG_FILT_LO] = fs;
        w[`PCG_CFG_INDEX_HI:`PCG_CFG_INDEX_LO] = ix;
        return w;
    endfunction

    // ==============================================================
    // Bus slave: one registered ack per request, one cycle after it
    pcg_pkg::pcg_bus_e busState;
    logic req;
    logic wrStrobe;
    logic [31:0] wMask;
    logic [31:0] wData;
    logic [7:0] slot;
    logic [GSW-1:0] gSel;
    logic [4:0] wordSel;

    assign req = wbCyc && wbStb && (busState == pcg_pkg::PCG_BUS_IDLE);
    // Writes land on the edge at which the master sees ack
    assign wrStrobe = wbCyc && wbStb && wbWe && wbAck;
    assign wMask = laneMask(wbSel);
    assign wData = wbDatW & wMask;
    assign slot = {2'b00, wbAdr[7:2]};
    assign gSel = slot[GSW-1:0];
    assign wordSel = wbAdr[6:2];

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            busState <= pcg_pkg::PCG_BUS_IDLE;
        end else begin
            unique case (busState)
                pcg_pkg::PCG_BUS_IDLE: begin
                    if (wbCyc && wbStb) begin
                        busState <= pcg_pkg::PCG_BUS_ACK;
                    end
                end
                pcg_pkg::PCG_BUS_ACK: begin
                    busState <= pcg_pkg::PCG_BUS_IDLE;
                end
                default: begin
                    busState <= pcg_pkg::PCG_BUS_IDLE;
                end
            endcase
        end
    end

    assign wbAck = (busState == pcg_pkg::PCG_BUS_ACK);

    // ==============================================================
    // Monitor control and wide stream ID control
    logic wideIdEnable;
    logic exportAll;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            globalEnable <= 1'b0;
            exportAll <= 1'b0;
        end else if (wrStrobe && wbAdr == `PCG_OFS_MONITOR_CONTROL
                     && wbSel[0]) begin
            globalEnable <= wbDatW[`PCG_MC_ENABLE];
            exportAll <= wbDatW[`PCG_MC_EXPORT];
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            wideIdEnable <= 1'b0;
        end else if (wrStrobe && wbAdr == `PCG_OFS_WIDE_ID_CTRL
                     && wbSel[0]) begin
            wideIdEnable <= wbDatW[0];
        end
    end

    // ==============================================================
    // Per-group configuration and stream match
    logic [GROUPS-1:0] grpExport;
    logic [GROUPS-1:0] grpEnable;
    logic [GROUPS-1:0] grpReveal;
    logic [1:0] grpFilter [GROUPS];
    logic [7:0] grpIndex [GROUPS];
    logic [15:0] smMask [GROUPS];
    logic [15:0] smId [GROUPS];
    logic [GROUPS-1:0] groupPass;
    logic [15:0] liveMask;

    assign liveMask = idMask(wideIdEnable);

    genvar g;
    generate
        for (g = 0; g < GROUPS; g++) begin : gGroup
            logic cfgHit;
            logic smHit;
            logic [31:0] oldCfg;
            logic [31:0] newCfg;
            logic [31:0] newSm;
            logic [15:0] sid;
            logic [15:0] cmpMask;

            assign cfgHit = wrStrobe && inPage(wbAdr, OFS_CFG)
                && slot == 8'(g);
            assign smHit = wrStrobe && inPage(wbAdr, OFS_SM)
                && slot == 8'(g);
            assign oldCfg = packCfg(grpExport[g], grpEnable[g],
                grpReveal[g], grpFilter[g], grpIndex[g]);
            assign newCfg = (oldCfg & ~wMask) | wData;
            assign newSm = ({smMask[g], smId[g]} & ~wMask) | wData;

            // Total and tag fields have no storage: writes are lost
            always_ff @(posedge mclk) begin
                if (!nrst) begin
                    grpExport[g] <= 1'b0;
                    grpEnable[g] <= 1'b0;
                    grpReveal[g] <= 1'b0;
                    grpFilter[g] <= 2'h0;
                    grpIndex[g] <= 8'h00;
                end else if (cfgHit) begin
                    grpExport[g] <= newCfg[`PCG_CFG_EXPORT];
                    grpEnable[g] <= newCfg[`PCG_CFG_ENABLE];
                    grpReveal[g] <= newCfg[`PCG_CFG_REVEAL];
                    grpFilter[g] <=
                        newCfg[`PCG_CFG_FILT_HI:`PCG_CFG_FILT_LO];
                    grpIndex[g] <=
                        newCfg[`PCG_CFG_INDEX_HI:`PCG_CFG_INDEX_LO];
                end
            end

            always_ff @(posedge mclk) begin
                if (!nrst) begin
                    smMask[g] <= 16'h0000;
                    smId[g] <= 16'h0000;
                end else if (smHit) begin
                    smMask[g] <= newSm[31:16] & idMask(1'b1);
                    smId[g] <= newSm[15:0] & idMask(1'b1);
                end
            end

            assign sid = eventStreamId[g*16 +: 16];
            assign cmpMask = ~smMask[g] & liveMask;

            always_comb begin
                unique case (pcg_pkg::pcg_filter_e'(grpFilter[g]))
                    pcg_pkg::PCG_FILT_GLOBAL: groupPass[g] = 1'b1;
                    pcg_pkg::PCG_FILT_STREAM:
                        groupPass[g] = ((sid ^ smId[g]) & cmpMask) == '0;
                    pcg_pkg::PCG_FILT_BANK:
                        groupPass[g] = eventBank[g*8 +: 8] == grpIndex[g];
                    default: groupPass[g] = 1'b0;
                endcase
            end

            assign groupExport[g] = grpExport[g] & exportAll;
            assign groupReveal[g] = grpReveal[g];
            assign groupRevealBank[g*8 +: 8] = grpIndex[g];
        end
    endgenerate

    // ==============================================================
    // Shared per-counter enable state
    logic [SETREGS*32-1:0] cntEnable;

    genvar x;
    generate
        for (x = 0; x < SETREGS; x++) begin : gSet
            logic setHit;
            logic clrHit;
            assign setHit = wrStrobe && inHalfPage(wbAdr, OFS_SET)
                && wordSel == 5'(x);
            assign clrHit = wrStrobe && inHalfPage(wbAdr, OFS_CLR)
                && wordSel == 5'(x);
            always_ff @(posedge mclk) begin
                if (!nrst) begin
                    cntEnable[x*32 +: 32] <= `PCG_RST_WORD;
                end else if (setHit) begin
                    cntEnable[x*32 +: 32] <= (cntEnable[x*32 +: 32]
                        | wData) & setMask(x);
                end else if (clrHit) begin
                    cntEnable[x*32 +: 32] <= cntEnable[x*32 +: 32]
                        & ~wData & setMask(x);
                end
            end
        end
    endgenerate

    // ==============================================================
    // Counter increment qualification
    genvar c;
    generate
        for (c = 0; c < COUNTERS; c++) begin : gCnt
            localparam int G = (c * GROUPS) / COUNTERS;
            assign counterIncrement[c] = globalEnable && grpEnable[G]
                && cntEnable[c] && eventValid[G] && groupPass[G];
        end
    endgenerate

    // ==============================================================
    // Read data: word chosen now, held from the taken edge
    logic [31:0] next_wbDatR;

    always_comb begin
        next_wbDatR = 32'h0000_0000;
        if (wbAdr == `PCG_OFS_MONITOR_CONTROL) begin
            next_wbDatR = {27'h0, exportAll, 3'h0, globalEnable};
        end else if (wbAdr == `PCG_OFS_WIDE_ID_CTRL) begin
            next_wbDatR = {31'h0, wideIdEnable};
        end else if (inPage(wbAdr, OFS_CFG) && slot < 8'(GROUPS)) begin
            next_wbDatR = packCfg(grpExport[gSel], grpEnable[gSel],
                grpReveal[gSel], grpFilter[gSel], grpIndex[gSel]);
            next_wbDatR[`PCG_CFG_TOTAL_HI:`PCG_CFG_TOTAL_LO] =
                GROUP_TOTAL;
            next_wbDatR[`PCG_CFG_TAG_HI:`PCG_CFG_TAG_LO] =
                7'(TAG_BASE + 7'(slot));
        end else if (inPage(wbAdr, OFS_SM) && slot < 8'(GROUPS)) begin
            next_wbDatR = {smMask[gSel], smId[gSel]};
        end else if ((inHalfPage(wbAdr, OFS_SET)
                      || inHalfPage(wbAdr, OFS_CLR))
                     && wordSel < 5'(SETREGS)) begin
            // Both windows show the one shared state
            next_wbDatR = cntEnable[wordSel*32 +: 32];
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            wbDatR <= 32'h0000_0000;
        end else if (req && !wbWe) begin
            wbDatR <= next_wbDatR;
        end
    end

endmodule

`default_nettype wire

/* File: hdl/pcg_pkg.sv */
// Types of the counter group control block.
// Assumes pcg_consts.svh is compiled alongside.
`default_nettype none

package pcg_pkg;
    typedef enum logic [1:0] {
        PCG_FILT_GLOBAL = 2'h0,
        PCG_FILT_STREAM = 2'h1,
        PCG_FILT_BANK = 2'h2,
        PCG_FILT_RSVD = 2'h3
    } pcg_filter_e;

    typedef enum logic [1:0] {
        PCG_BUS_IDLE = 2'h1,
        PCG_BUS_ACK = 2'h2
    } pcg_bus_e;
endpackage

`default_nettype wire
